// *** hdl/svp_defines.vh ***
// Constants for the segmented vector pipeline.
// Assumes inclusion by bare name from the design files.
`ifndef SVP_DEFINES_VH
`define SVP_DEFINES_VH
`define SVP_WORD_W 64
`define SVP_IDX_W 7
`define SVP_LEN_W 8
`define SVP_MAX_LEN 8'h40
`define SVP_STAGES 5
`define SVP_FIFO_DEPTH 32
`define SVP_FIFO_AW 5
`define SVP_OP_W 2
`define SVP_OP_ADD 2'h0
`define SVP_OP_AND 2'h1
`define SVP_OP_OR 2'h2
`define SVP_OP_XOR 2'h3
`define SVP_ST_IDLE 2'h0
`define SVP_ST_RUN 2'h1
`define SVP_ST_DRAIN 2'h2
`endif

// *** hdl/svp_fifo.v ***
// Result buffer: synchronous FIFO with valid/ready on both sides.
// Assumes one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module svp_fifo #(
	parameter WIDTH = 71,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire clk,
	input wire rstn,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;

	// Honest flags from the occupancy count
	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	// Storage array, no reset needed on data
	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and count
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** hdl/svp_pipe.v ***
// Segmented vector functional unit with element sequencer and result buffer.
// Assumes the register file supplies operands combinationally by index,
// and drains results through a valid/ready write port.
`timescale 1ns/1ps
`default_nettype none
`include "svp_defines.vh"
module svp_pipe (
	input wire CLK_SYS,
	input wire RSTN,
	input wire ISSUE,
	input wire [`SVP_OP_W-1:0] OP_SEL,
	input wire SCALAR_MODE,
	input wire [`SVP_WORD_W-1:0] SCALAR_IN,
	input wire [`SVP_LEN_W-1:0] VECTOR_LENGTH_COUNT,
	output reg [`SVP_IDX_W-1:0] SRC_INDEX,
	output wire SRC_READ,
	input wire [`SVP_WORD_W-1:0] SRC_J_DATA,
	input wire [`SVP_WORD_W-1:0] SRC_K_DATA,
	output wire RES_VALID,
	input wire RES_READY,
	output wire [`SVP_IDX_W-1:0] RES_INDEX,
	output wire [`SVP_WORD_W-1:0] RES_DATA,
	output wire BUSY
);
	// Operands, scalar and results share one word width
	localparam W = `SVP_WORD_W;
	localparam NS = `SVP_STAGES;
	localparam FW = `SVP_WORD_W + `SVP_IDX_W;
	localparam ST_IDLE = `SVP_ST_IDLE;
	localparam ST_RUN = `SVP_ST_RUN;
	localparam ST_DRAIN = `SVP_ST_DRAIN;

	// Run bookkeeping: captured length, issue and write counters
	reg [1:0] state;
	reg [1:0] next_state;
	reg [`SVP_LEN_W-1:0] length;
	reg [`SVP_LEN_W-1:0] issued;
	reg [`SVP_LEN_W-1:0] written;
	reg [W-1:0] scalar;
	reg [`SVP_OP_W-1:0] op;
	reg use_scalar;
	reg [`SVP_LEN_W-1:0] next_len;

	// Stage registers: data, valid, destination index per stage
	reg [W-1:0] st_data [0:NS-1];
	reg [W-1:0] st_aux [0:NS-1];
	reg [NS-1:0] st_valid;
	reg [`SVP_IDX_W-1:0] st_idx [0:NS-1];

	wire fifo_in_ready;
	wire [FW-1:0] fifo_out;
	wire stall;
	wire enter;
	wire [W-1:0] opnd_k;
	wire write_done;

	// Back-pressure: freeze the whole pipe when the buffer cannot take
	// the result leaving stage five; costs a little throughput under stall.
	// Issue freezes as well, so no operand is read without a slot for it.
	assign stall = st_valid[NS-1] && !fifo_in_ready;
	assign enter = (state == ST_RUN) && (issued != length) && !stall;
	assign SRC_READ = enter;
	assign opnd_k = use_scalar ? scalar : SRC_K_DATA;
	assign write_done = RES_VALID && RES_READY;

	// Clamp length to register size; a zero length reads nothing
	// but still passes one cycle each through run and drain.
	always @* begin
		next_len = VECTOR_LENGTH_COUNT;
		if (VECTOR_LENGTH_COUNT > `SVP_MAX_LEN) begin
			next_len = `SVP_MAX_LEN;
		end
	end

	// Sequencer next state
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (ISSUE) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (issued == length) begin
					next_state = ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				if (written == length) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Busy falls once the last buffered result has been written
	assign BUSY = (state != ST_IDLE);

	// Sequencer registers and issue capture
	// ISSUE is ignored while busy; the captured copies hold for the run.
	always @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			state <= ST_IDLE;
			length <= {`SVP_LEN_W{1'b0}};
			issued <= {`SVP_LEN_W{1'b0}};
			written <= {`SVP_LEN_W{1'b0}};
			scalar <= {W{1'b0}};
			op <= `SVP_OP_ADD;
			use_scalar <= 1'b0;
			SRC_INDEX <= {`SVP_IDX_W{1'b0}};
		end else begin
			state <= next_state;
			if (state == ST_IDLE && ISSUE) begin
				length <= next_len;
				scalar <= SCALAR_IN;
				op <= OP_SEL;
				use_scalar <= SCALAR_MODE;
				issued <= {`SVP_LEN_W{1'b0}};
				written <= {`SVP_LEN_W{1'b0}};
				SRC_INDEX <= {`SVP_IDX_W{1'b0}};
			end else begin
				if (enter) begin
					issued <= issued + 1'b1;
					SRC_INDEX <= SRC_INDEX + 1'b1;
				end
				if (write_done) begin
					written <= written + 1'b1;
				end
			end
		end
	end

	// Stage one: logic operations finish here; for an add the j operand
	// waits here while the k operand rides alongside in the aux word.
	// The captured op is stable for the whole run, so no per-stage copy.
	always @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			st_valid[0] <= 1'b0;
			st_data[0] <= {W{1'b0}};
			st_aux[0] <= {W{1'b0}};
			st_idx[0] <= {`SVP_IDX_W{1'b0}};
		end else if (!stall) begin
			st_valid[0] <= enter;
			st_idx[0] <= SRC_INDEX;
			st_aux[0] <= opnd_k;
			case (op)
				`SVP_OP_AND: st_data[0] <= SRC_J_DATA & opnd_k;
				`SVP_OP_OR: st_data[0] <= SRC_J_DATA | opnd_k;
				`SVP_OP_XOR: st_data[0] <= SRC_J_DATA ^ opnd_k;
				default: st_data[0] <= SRC_J_DATA;
			endcase
		end
	end

	// Later stages shift forward one per clock. The whole 64-bit add sits
	// in the second stage; the remaining stages only carry the result,
	// which keeps the unit time fixed whatever the operation. Splitting
	// the carry over several stages would ease timing but cost more flops.
	genvar g;
	generate
		for (g = 1; g < NS; g = g + 1) begin : g_stage
			always @(posedge CLK_SYS or negedge RSTN) begin
				if (!RSTN) begin
					st_valid[g] <= 1'b0;
					st_data[g] <= {W{1'b0}};
					st_aux[g] <= {W{1'b0}};
					st_idx[g] <= {`SVP_IDX_W{1'b0}};
				end else if (!stall) begin
					st_valid[g] <= st_valid[g-1];
					st_idx[g] <= st_idx[g-1];
					if (op == `SVP_OP_ADD && g == 1) begin
						st_data[g] <= st_data[g-1] + st_aux[g-1];
					end else begin
						st_data[g] <= st_data[g-1];
					end
					st_aux[g] <= st_aux[g-1];
				end
			end
		end
	endgenerate

	// Result buffer after stage five: fixed latency into the buffer while it has room
	// The buffer adds one cycle: a result shows six clocks after entry.
	svp_fifo #(
		.WIDTH(FW),
		.DEPTH(`SVP_FIFO_DEPTH),
		.AW(`SVP_FIFO_AW)
	) u_fifo (
		.clk(CLK_SYS),
		.rstn(RSTN),
		.in_valid(st_valid[NS-1]),
		.in_ready(fifo_in_ready),
		.in_data({st_idx[NS-1], st_data[NS-1]}),
		.out_valid(RES_VALID),
		.out_ready(RES_READY),
		.out_data(fifo_out)
	);

	// Results to successive destination elements
	assign RES_DATA = fifo_out[W-1:0];
	assign RES_INDEX = fifo_out[FW-1:W];
	// Independent unit: no shared resources with sibling pipes
	// Several instances may run different operations side by side.
endmodule
`default_nettype wire

// *** verification/svp_pipe_asserts.sv ***
// Port checker for the vector pipeline.
// Needs one clock and an async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module svp_chk (
	input wire CLK_SYS,
	input wire RSTN,
	input wire ISSUE,
	input wire [7:0] VECTOR_LENGTH_COUNT,
	input wire SRC_READ,
	input wire [6:0] SRC_INDEX,
	input wire RES_VALID,
	input wire RES_READY,
	input wire [6:0] RES_INDEX,
	input wire BUSY
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	// Issue only counts while idle
	wire take = ISSUE && !BUSY;
	sequence first_out;
		// Entry cycle, five stages, then one buffer cycle
		!RES_VALID [*5] ##1 (RES_VALID && RES_INDEX == 7'h0);
	endsequence
	AST_FIRST: assert property (take && VECTOR_LENGTH_COUNT != 8'h0
		|=> SRC_READ && SRC_INDEX == 7'h0) else $error("bad first");
	AST_STEP: assert property (SRC_READ ##1 SRC_READ
		|-> SRC_INDEX == $past(SRC_INDEX) + 7'h1) else $error("bad step");
	AST_LAT: assert property ($rose(BUSY) && SRC_READ && !RES_VALID |=> first_out)
		else $error("bad latency");
	AST_ORDER: assert property (RES_VALID && RES_READY ##1 RES_VALID
		|-> RES_INDEX == $past(RES_INDEX) + 7'h1) else $error("bad order");
	AST_BUSY: assert property (take |=> BUSY) else $error("no busy");
	AST_CAUSE: assert property ($rose(BUSY) |-> $past(ISSUE)) else $error("stray busy");
	AST_IDLE: assert property (!BUSY |-> !SRC_READ) else $error("idle read");
	AST_LEN0: assert property (take && VECTOR_LENGTH_COUNT == 8'h0
		|=> (BUSY && !SRC_READ) [*2] ##1 !BUSY) else $error("bad empty run");
endmodule
bind svp_pipe svp_chk svp_chk_inst (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .ISSUE(ISSUE),
	.VECTOR_LENGTH_COUNT(VECTOR_LENGTH_COUNT), .SRC_READ(SRC_READ), .SRC_INDEX(SRC_INDEX),
	.RES_VALID(RES_VALID), .RES_READY(RES_READY), .RES_INDEX(RES_INDEX), .BUSY(BUSY));
`default_nettype wire

// *** verification/svp_rf_model.sv ***
// Register file model for the pipeline.
// Reads by index, no clock.
`timescale 1ns/1ps
`default_nettype none
module svp_rf_model (
	input wire logic rd,
	input wire logic [6:0] idx,
	input wire logic [63:0] seed,
	output logic [63:0] j,
	output logic [63:0] k
);
	// Unselected reads show inverted data, never stale words
	assign j = (seed + idx) ^ {64{!rd}};
	assign k = (~seed ^ idx) ^ {64{!rd}};
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the vector pipeline.
// Uses the register file model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, rstn, iss, sm, rdy, rd, vld, busy, hold;
	logic [1:0] op;
	logic [6:0] sidx, ridx;
	logic [7:0] len;
	logic [31:0] r = 32'h2d;
	logic [63:0] sc, esc, seed, jd, kd, rdat;
	int fails, checks_done, nres;
	function automatic logic [31:0] nxt(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Scalar from the issue-time copy, not the live input
	function automatic logic [63:0] want(int i);
		logic [63:0] a, b;
		a = seed + i[6:0];
		b = sm ? esc : ~seed ^ i[6:0];
		return op == 2'h0 ? a + b : op == 2'h1 ? a & b : op == 2'h2 ? a | b : a ^ b;
	endfunction
	task automatic cmp(logic [63:0] got, logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Hang guard, well beyond the longest run
	initial begin
		#400000;
		fails++;
		report_and_stop;
	end
	svp_pipe svp_pipe_inst (.CLK_SYS(clk), .RSTN(rstn), .ISSUE(iss), .OP_SEL(op),
		.SCALAR_MODE(sm), .SCALAR_IN(sc), .VECTOR_LENGTH_COUNT(len), .SRC_INDEX(sidx),
		.SRC_READ(rd), .SRC_J_DATA(jd), .SRC_K_DATA(kd), .RES_VALID(vld), .RES_READY(rdy),
		.RES_INDEX(ridx), .RES_DATA(rdat), .BUSY(busy));
	svp_rf_model svp_rf_model_inst (.rd(rd), .idx(sidx), .seed(seed), .j(jd), .k(kd));
	// Random drain stalls; hold forces the buffer full
	always @(posedge clk) begin
		r <= nxt(r);
		rdy <= !hold && (r[0] || r[1]);
	end
	// Drained results against the expected stream
	always @(posedge clk) begin
		if (vld && rdy) begin
			cmp(ridx, nres[6:0]);
			cmp(rdat, want(nres));
			nres++;
		end
	end
	task automatic run(logic [1:0] o, logic m, logic [7:0] l, logic h);
		@(posedge clk);
		nres = 0;
		esc = {r, nxt(r)};
		{iss, op, sm, len, hold} <= {1'b1, o, m, l, h};
		{sc, seed} <= {esc, nxt(r), r};
		@(posedge clk);
		{iss, sc, len} <= {1'b0, ~esc, 8'h7};
		@(posedge clk);
		iss <= l > 8'h7;
		@(posedge clk);
		iss <= 1'b0;
		repeat (40) @(posedge clk);
		hold <= 1'b0;
		for (int c = 0; c < 3000 && (busy || vld); c++)
			@(negedge clk);
		// A run that never drains counts as a mismatch
		if (busy !== 1'b0 || vld !== 1'b0)
			fails++;
		cmp(nres, l > 8'h40 ? 8'h40 : l);
	endtask
	initial begin
		{rstn, iss, sm, rdy, hold, op, len, sc, seed} = '0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		run(2'h0, 1'b0, 8'h40, 1'b1);
		run(2'h1, 1'b1, 8'h0, 1'b0);
		run(2'h2, 1'b0, 8'h1, 1'b0);
		run(2'h3, 1'b1, 8'h80, 1'b0);
		for (int t = 0; t < 12; t++)
			run(t[1:0], t[2], r[7:0], t[3]);
		report_and_stop;
	end
endmodule
`default_nettype wire
